// ===== mgmt_regs.svh
// Constants of the management serial unit: timing, frame fields, register indices
// Overview of operation
// - Slave read: Z turnaround bit, drive low, sixteen data bits, then release.
// - Repeated half-word read restarts pairing silently as a new pair.
// - Registers flagged 16-bit readable need no second half-word read.
// - Unused addresses read as zeros with the data line still driven.
// - First half-word captures full 32-bit value, held through the second.
// - Read side effects fire when the second half shift starts, unchecked.
// - Live-bit hardware events are deferred until the read indication.
// - Reads during reset never leave the slave awaiting a second half.
// - Slave never drives the data line during write frames.
// - Slave samples on host clock rise, updates output a few clocks later.
// - Master runs standard management protocol at 2.5 MHz.
// - Master clock has 400 ns period, 50/50 duty.
// - Master frame: 32 ones, 01, opcode, addresses, turnaround, data, MSB first.
// - Master write turnaround is 1 then 0, then data MSB.
// - Idle master releases data line, keeps driving its clock.
// - Master changes data 120 ns after rise, samples 40 ns before rise.
// - Master reaches internal and external PHYs on the port pins.
// - EEPROM loader can write the master access and data registers.
// - Slave frames need PHY address bit 4; fields map to register address.
// - Half select set moves bytes 3,2; clear moves bytes 1,0.
// - Outside full power the slave ignores all pin activity.
// - Writing the access register starts a PHY management frame unless the master is busy.
`ifndef MGMT_REGS_SVH
`define MGMT_REGS_SVH

`define MCLK_PERIOD_NS  20
`define MDC_PERIOD_NS   400
`define MDC_DIV         (`MDC_PERIOD_NS / `MCLK_PERIOD_NS)
`define MDC_HIGH_CYC    (`MDC_DIV / 2)
`define MDO_DELAY_NS    120
`define MDO_DELAY_CYC   (`MDO_DELAY_NS / `MCLK_PERIOD_NS)
`define MDI_LEAD_NS     40
`define MDI_SAMPLE_CYC  (`MDC_DIV - (`MDI_LEAD_NS / `MCLK_PERIOD_NS))

`define PREAMBLE_LEN    6'h20
`define FRAME_LAST      6'h3f
`define FRAME_TA_BIT    6'h2e
`define FRAME_DATA_BIT  6'h30
`define HDR_LAST        5'h0c
`define DATA_LAST       5'h0f
`define OP_READ         2'h2
`define OP_WRITE        2'h1
`define TA_WRITE        2'h2

`define PHY_DATA_IDX    8'h29
`define PHY_ACCESS_IDX  8'h2a
`define ACC_ADDR_LSB    11
`define ACC_IDX_LSB     6
`define ACC_WNR_BIT     1
`define ACC_BUSY_BIT    0
`define PHY_DATA_RST    16'h0000

`endif

// ===== mgmt_pkg.sv
// Types shared by the management serial unit
package mgmt_pkg;

  typedef enum logic [2:0] {SL_PRE, SL_HDR, SL_TA, SL_RD, SL_WR} slave_state_t;

  typedef struct packed {
    logic bit_v;
    logic tog;
  } link_st_t;

  typedef struct packed {
    logic [4:0]  ph;
    logic [5:0]  cnt;
    logic        act;
    logic        lead;
    logic        wnr;
    logic [63:0] frame;
    logic [15:0] rd;
    logic        done;
    logic        mdo;
    logic        oe;
    logic        mdc;
    logic [1:0]  isync;
  } master_st_t;

  typedef struct packed {
    slave_state_t st;
    logic [2:0]   tsync;
    logic [1:0]   bsync;
    logic [5:0]   ones;
    logic [4:0]   cnt;
    logic [12:0]  hdr;
    logic [15:0]  sh;
    logic [31:0]  latch;
    logic [7:0]   addr;
    logic         half;
    logic         req;
    logic         pend;
    logic         pend_half;
    logic         commit_due;
    logic         commit;
    logic         wr_have;
    logic         wr_half;
    logic [15:0]  wr_part;
    logic         wr;
    logic [7:0]   waddr;
    logic [31:0]  wdata;
    logic         out;
    logic         oe;
    logic [4:0]   acc_phy;
    logic [4:0]   acc_idx;
    logic         acc_wnr;
    logic [15:0]  pdata;
    logic         start;
  } top_st_t;

endpackage : mgmt_pkg

// ===== mgmt_link_sampler.sv
// Host clock domain front end of the serial register port
`timescale 1ns/10ps
module mgmt_link_sampler
  import mgmt_pkg::*;
(
  // Link clock and reset
  input  wire logic mdc_link,
  input  wire logic rst,
  // Data pin and captured bit
  input  wire logic mdio_in,
  output logic      bit_v,
  output logic      bit_tog
);

  link_st_t s_q;
  link_st_t s_d;

  // Bit holds a full host period, so a level sync of it is safe once the toggle arrives
  always_comb begin
    s_d       = s_q;
    s_d.bit_v = mdio_in;
    s_d.tog   = ~s_q.tog;
  end

  always_ff @(posedge mdc_link or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bit_v   = s_q.bit_v;
  assign bit_tog = s_q.tog;

endmodule : mgmt_link_sampler

// ===== phy_mgmt_master.sv
// PHY management frame engine with its own divided management clock
`timescale 1ns/10ps
`include "mgmt_regs.svh"
module phy_mgmt_master
  import mgmt_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Command
  input  wire logic        start,
  input  wire logic        wnr,
  input  wire logic [4:0]  phy_addr,
  input  wire logic [4:0]  reg_idx,
  input  wire logic [15:0] wr_data,
  output logic             busy,
  output logic             done,
  output logic [15:0]      rd_data,
  // Management pins
  output logic             mgmt_clock,
  input  wire logic        mgmt_data_in,
  output logic             mgmt_data_out,
  output logic             mgmt_data_oe
);

  master_st_t s_q;
  master_st_t s_d;
  logic [5:0] nxt_cnt;

  always_comb begin
    s_d       = s_q;
    s_d.done  = 1'b0;
    s_d.isync = {s_q.isync[0], mgmt_data_in};
    nxt_cnt   = s_q.cnt + 6'h01;
    // Free-running divider; the clock keeps toggling while idle
    s_d.ph  = (s_q.ph == 5'(`MDC_DIV - 1)) ? 5'h00 : s_q.ph + 5'h01;
    s_d.mdc = (s_d.ph < 5'(`MDC_HIGH_CYC));
    if (start && !s_q.act) begin
      s_d.act   = 1'b1;
      s_d.lead  = 1'b1;
      s_d.wnr   = wnr;
      s_d.cnt   = 6'h00;
      s_d.frame = {32'hffffffff, 2'h1, wnr ? `OP_WRITE : `OP_READ,
                   phy_addr, reg_idx, `TA_WRITE, wr_data};
    end else if (s_q.act && s_d.ph == 5'(`MDO_DELAY_CYC)) begin
      if (s_q.lead) begin
        s_d.lead = 1'b0;
        s_d.oe   = 1'b1;
        s_d.mdo  = s_q.frame[63];
      end else if (s_q.cnt == `FRAME_LAST) begin
        s_d.act  = 1'b0;
        s_d.oe   = 1'b0;
        s_d.mdo  = 1'b1;
        s_d.done = 1'b1;
      end else begin
        s_d.frame = {s_q.frame[62:0], 1'b0};
        s_d.cnt   = nxt_cnt;
        s_d.mdo   = s_q.frame[62];
        // Reads hand the line to the PHY for turnaround and data
        s_d.oe    = s_q.wnr || (nxt_cnt < `FRAME_TA_BIT);
      end
    end
    if (s_q.act && !s_q.lead && !s_q.wnr && s_q.cnt >= `FRAME_DATA_BIT &&
        s_d.ph == 5'(`MDI_SAMPLE_CYC)) begin
      s_d.rd = {s_q.rd[14:0], s_q.isync[1]};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q     <= '0;
      s_q.mdo <= 1'b1;
      // Divider restarts at its wrap point so the first high phase is a full one
      s_q.ph  <= 5'(`MDC_DIV - 1);
    end else begin
      s_q <= s_d;
    end
  end

  assign busy          = s_q.act;
  assign done          = s_q.done;
  assign rd_data       = s_q.rd;
  assign mgmt_clock    = s_q.mdc;
  assign mgmt_data_out = s_q.mdo;
  assign mgmt_data_oe  = s_q.oe;

endmodule : phy_mgmt_master

// ===== mgmt_serial_top.sv
// Management serial unit: serial register slave port and PHY management master
`timescale 1ns/10ps
`include "mgmt_regs.svh"
module mgmt_serial_top
  import mgmt_pkg::*;
(
  // Clocks and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        mdc_link,
  // Serial register port data pin
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  // Device status
  input  wire logic        full_power_state,
  input  wire logic        device_ready,
  // Internal register read path
  output logic             csr_rd_req,
  output logic [7:0]       csr_rd_addr,
  input  wire logic [31:0] csr_rd_data,
  input  wire logic        csr_rd_hit,
  input  wire logic        csr_rd_single,
  output logic             csr_rd_commit,
  output logic             csr_rd_hold,
  // Internal register write path
  output logic             csr_wr,
  output logic [7:0]       csr_wr_addr,
  output logic [31:0]      csr_wr_data,
  // EEPROM loader writes
  input  wire logic        eep_wr,
  input  wire logic [7:0]  eep_addr,
  input  wire logic [31:0] eep_data,
  // Port zero PHY management pins
  output logic             port0_mgmt_clock,
  input  wire logic        port0_mgmt_data_in,
  output logic             port0_mgmt_data_out,
  output logic             port0_mgmt_data_oe
);

  // ************************************************************
  // Link front end
  // ************************************************************

  logic link_bit;
  logic link_tog;

  mgmt_link_sampler u_link (
    .mdc_link (mdc_link),
    .rst      (rst),
    .mdio_in  (mdio_in),
    .bit_v    (link_bit),
    .bit_tog  (link_tog)
  );

  // ************************************************************
  // PHY management master
  // ************************************************************

  logic        m_busy;
  logic        m_done;
  logic [15:0] m_rd;

  top_st_t s_q;
  top_st_t s_d;

  phy_mgmt_master u_master (
    .mclk          (mclk),
    .rst           (rst),
    .start         (s_q.start),
    .wnr           (s_q.acc_wnr),
    .phy_addr      (s_q.acc_phy),
    .reg_idx       (s_q.acc_idx),
    .wr_data       (s_q.pdata),
    .busy          (m_busy),
    .done          (m_done),
    .rd_data       (m_rd),
    .mgmt_clock    (port0_mgmt_clock),
    .mgmt_data_in  (port0_mgmt_data_in),
    .mgmt_data_out (port0_mgmt_data_out),
    .mgmt_data_oe  (port0_mgmt_data_oe)
  );

  // ************************************************************
  // Slave frame engine and register paths
  // ************************************************************

  logic        ev;
  logic        b;
  logic [12:0] hdr_n;
  logic [15:0] wd16;
  logic [31:0] full;
  logic [31:0] int_val;
  logic        int_hit;
  logic        hdr_ok;
  logic        second;
  logic        mw;
  logic [7:0]  mi;
  logic [31:0] md;

  always_comb begin
    s_d        = s_q;
    s_d.commit = 1'b0;
    s_d.wr     = 1'b0;
    s_d.start  = 1'b0;
    s_d.req    = 1'b0;
    mw         = 1'b0;
    mi         = 8'h00;
    md         = 32'h00000000;
    full       = 32'h00000000;
    // The bit synchroniser feeds logic from its second stage, the toggle one from its second and third
    s_d.tsync  = {s_q.tsync[1:0], link_tog};
    s_d.bsync  = {s_q.bsync[0], link_bit};
    b          = s_q.bsync[1];
    ev         = (s_q.tsync[2] != s_q.tsync[1]) && full_power_state;
    hdr_n      = {s_q.hdr[11:0], b};
    wd16       = {s_q.sh[14:0], b};
    hdr_ok     = hdr_n[12] && hdr_n[9] &&
                 (hdr_n[11:10] == `OP_READ || hdr_n[11:10] == `OP_WRITE);
    second     = s_q.pend && (s_q.pend_half != hdr_n[0]);

    // Registers of the master that sit in the internal map
    int_hit = (s_q.addr == `PHY_DATA_IDX) || (s_q.addr == `PHY_ACCESS_IDX);
    if (s_q.addr == `PHY_ACCESS_IDX) begin
      int_val = {16'h0000, s_q.acc_phy, s_q.acc_idx, 4'h0, s_q.acc_wnr, m_busy};
    end else begin
      int_val = {16'h0000, s_q.pdata};
    end

    // Capture cycle: one clock after the header, the fabric answers combinationally
    if (s_q.req) begin
      if (int_hit) begin
        s_d.latch = int_val;
      end else begin
        s_d.latch = csr_rd_hit ? csr_rd_data : 32'h00000000;
      end
      // Before ready every read stands alone so no half is left owed
      s_d.pend       = !(csr_rd_single || !device_ready) || 1'b0;
      s_d.pend_half  = s_q.half;
      s_d.commit_due = csr_rd_single || !device_ready;
    end

    if (!device_ready) begin
      s_d.pend    = 1'b0;
      s_d.wr_have = 1'b0;
    end

    if (!full_power_state) begin
      s_d.st   = SL_PRE;
      s_d.oe   = 1'b0;
      s_d.out  = 1'b1;
      s_d.ones = 6'h00;
    end else if (ev) begin
      unique case (s_q.st)
        SL_PRE: begin
          if (b) begin
            s_d.ones = (s_q.ones == `PREAMBLE_LEN) ? s_q.ones : s_q.ones + 6'h01;
          end else begin
            s_d.ones = 6'h00;
            if (s_q.ones == `PREAMBLE_LEN) begin
              s_d.st  = SL_HDR;
              s_d.cnt = 5'h00;
              s_d.hdr = 13'h0000;
            end
          end
        end
        SL_HDR: begin
          s_d.hdr = hdr_n;
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == `HDR_LAST) begin
            s_d.cnt = 5'h00;
            if (!hdr_ok) begin
              s_d.st = SL_PRE;
            end else begin
              s_d.st   = SL_TA;
              s_d.half = hdr_n[0];
              if (hdr_n[11:10] == `OP_READ) begin
                if (second) begin
                  s_d.pend       = 1'b0;
                  s_d.commit_due = 1'b1;
                end else begin
                  // New pair, or a repeated half that restarts the pair
                  s_d.req  = 1'b1;
                  s_d.addr = {hdr_n[8:5], hdr_n[4:1]};
                  s_d.pend = 1'b0;
                end
              end
            end
          end
        end
        SL_TA: begin
          if (s_q.hdr[11:10] == `OP_READ) begin
            s_d.oe  = 1'b1;
            s_d.out = 1'b0;
            s_d.sh  = s_q.half ? s_q.latch[31:16] : s_q.latch[15:0];
            s_d.st  = SL_RD;
          end else begin
            s_d.cnt = s_q.cnt + 5'h01;
            if (s_q.cnt == 5'h01) begin
              s_d.cnt = 5'h00;
              s_d.st  = SL_WR;
            end
          end
        end
        SL_RD: begin
          if (s_q.cnt == `DATA_LAST + 5'h01) begin
            s_d.oe  = 1'b0;
            s_d.out = 1'b1;
            s_d.cnt = 5'h00;
            s_d.st  = SL_PRE;
          end else begin
            s_d.out = s_q.sh[15];
            s_d.sh  = {s_q.sh[14:0], 1'b0};
            s_d.cnt = s_q.cnt + 5'h01;
            if (s_q.cnt == 5'h00 && s_q.commit_due) begin
              s_d.commit     = 1'b1;
              s_d.commit_due = 1'b0;
            end
          end
        end
        SL_WR: begin
          s_d.sh  = wd16;
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == `DATA_LAST) begin
            s_d.cnt = 5'h00;
            s_d.st  = SL_PRE;
            // Halves are paired by select bit only; the address is not compared
            if (s_q.wr_have && s_q.wr_half != s_q.hdr[0]) begin
              s_d.wr_have = 1'b0;
              full = s_q.hdr[0] ? {wd16, s_q.wr_part} : {s_q.wr_part, wd16};
              mi   = {s_q.hdr[8:5], s_q.hdr[4:1]};
              if (mi == `PHY_DATA_IDX || mi == `PHY_ACCESS_IDX) begin
                mw = 1'b1;
                md = full;
              end else begin
                s_d.wr    = 1'b1;
                s_d.waddr = mi;
                s_d.wdata = full;
              end
            end else begin
              s_d.wr_have = 1'b1;
              s_d.wr_half = s_q.hdr[0];
              s_d.wr_part = wd16;
            end
          end
        end
      endcase
    end

    // The loader only fills in when the slave is not writing a master register the same cycle
    if (!mw && eep_wr) begin
      mw = (eep_addr == `PHY_DATA_IDX) || (eep_addr == `PHY_ACCESS_IDX);
      mi = eep_addr;
      md = eep_data;
    end

    if (m_done && !s_q.acc_wnr) begin
      s_d.pdata = m_rd;
    end

    if (mw && mi == `PHY_DATA_IDX) begin
      s_d.pdata = md[15:0];
    end else if (mw && mi == `PHY_ACCESS_IDX) begin
      s_d.acc_phy = md[`ACC_ADDR_LSB+4:`ACC_ADDR_LSB];
      s_d.acc_idx = md[`ACC_IDX_LSB+4:`ACC_IDX_LSB];
      s_d.acc_wnr = md[`ACC_WNR_BIT];
      s_d.start   = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q       <= '0;
      s_q.st    <= SL_PRE;
      s_q.out   <= 1'b1;
      s_q.pdata <= `PHY_DATA_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************

  assign mdio_out      = s_q.out;
  assign mdio_oe       = s_q.oe;
  assign csr_rd_req    = s_q.req && !int_hit;
  assign csr_rd_addr   = s_q.addr;
  assign csr_rd_commit = s_q.commit && !int_hit;
  // Fabric holds back live-bit events while a captured value is still owed its effects
  assign csr_rd_hold   = (s_q.pend || s_q.commit_due) && !int_hit;
  assign csr_wr        = s_q.wr;
  assign csr_wr_addr   = s_q.waddr;
  assign csr_wr_data   = s_q.wdata;

endmodule : mgmt_serial_top

// ===== mgmt_serial_checker.sv
// Concurrent checks on the ports of the management serial unit
`timescale 1ns/10ps
module mgmt_serial_checker (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst,
  // Observed ports
  input wire logic       full_power_state,
  input wire logic       mdio_out,
  input wire logic       mdio_oe,
  input wire logic       csr_rd_req,
  input wire logic [7:0] csr_rd_addr,
  input wire logic       csr_rd_commit,
  input wire logic       csr_rd_hold,
  input wire logic       port0_mgmt_clock,
  input wire logic       port0_mgmt_data_out,
  input wire logic       port0_mgmt_data_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ********************
  // Master clock and pins
  // ********************
  a_clk_high_time: assert property ($rose(port0_mgmt_clock) |->
    port0_mgmt_clock[*8] ##1 port0_mgmt_clock[*2] ##1 !port0_mgmt_clock)
    else $error("master clock high phase not ten cycles");
  a_clk_low_time: assert property ($fell(port0_mgmt_clock) |->
    !port0_mgmt_clock[*8] ##1 !port0_mgmt_clock[*2] ##1 port0_mgmt_clock)
    else $error("master clock low phase not ten cycles");
  a_data_mid_high: assert property (port0_mgmt_data_oe && $changed(port0_mgmt_data_out)
    |-> port0_mgmt_clock && $past(port0_mgmt_clock, 3))
    else $error("master data changed outside the high phase");
  a_oe_mid_high: assert property ($rose(port0_mgmt_data_oe)
    |-> port0_mgmt_clock && $past(port0_mgmt_clock, 3))
    else $error("master drive began outside the high phase");
  // ********************
  // Slave port
  // ********************
  a_idle_line_high: assert property (!mdio_oe |-> mdio_out)
    else $error("slave output not high while released");
  a_drive_low_first: assert property ($rose(mdio_oe) |-> !mdio_out)
    else $error("slave did not drive low first");
  a_low_power_quiet: assert property (!full_power_state |=> !mdio_oe && !csr_rd_req)
    else $error("slave active outside full power");
  a_req_one_pulse: assert property (csr_rd_req |=> !csr_rd_req)
    else $error("read request longer than one cycle");
  a_hold_after_req: assert property ($rose(csr_rd_hold) |-> $past(csr_rd_req))
    else $error("event hold without a capture");
  a_hold_addr_stable: assert property (csr_rd_hold |-> $stable(csr_rd_addr))
    else $error("read address moved while held");
  a_commit_ends_hold: assert property (csr_rd_commit |=> !csr_rd_hold)
    else $error("event hold outlived the read commit");
endmodule : mgmt_serial_checker

bind mgmt_serial_top mgmt_serial_checker chk_i (.mclk(mclk), .rst(rst),
  .full_power_state(full_power_state), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
  .csr_rd_req(csr_rd_req), .csr_rd_addr(csr_rd_addr), .csr_rd_commit(csr_rd_commit),
  .csr_rd_hold(csr_rd_hold), .port0_mgmt_clock(port0_mgmt_clock),
  .port0_mgmt_data_out(port0_mgmt_data_out), .port0_mgmt_data_oe(port0_mgmt_data_oe));

// ===== mgmt_host_model.sv
// Management host model driving the serial register port
`timescale 1ns/10ps
module mgmt_host_model (
  // Slave data pin
  input  wire logic mdio_out,
  input  wire logic mdio_oe,
  // Host side
  output logic      mdc_link,
  output logic      mdio_in
);
  logic h_oe;
  logic h_bit;
  // Pull-up holds the line whenever neither side drives
  assign mdio_in = mdio_oe ? mdio_out : (h_oe ? h_bit : 1'b1);
  initial begin
    mdc_link = 1'b0;
    h_oe = 1'b0;
    h_bit = 1'b1;
  end
  // Clock runs only within a frame; rd holds the second turnaround bit then data
  task automatic xfer(input logic [1:0] op, input logic [7:0] a, input logic half,
                      input logic [15:0] wd, output logic [16:0] rd, output logic drove);
    logic [63:0] f;
    f = {32'hffffffff, 2'b01, op, 1'b1, a, half, 2'b10, wd};
    rd = '0;
    drove = 1'b0;
    for (int i = 0; i < 64; i++) begin
      h_oe = (op == 2'h1) || (i < 46);
      h_bit = f[63 - i];
      #80 mdc_link = 1'b1;
      if (i > 46) rd = {rd[15:0], mdio_in};
      if (mdio_oe && (op == 2'h1 || i < 46)) drove = 1'b1;
      #80 mdc_link = 1'b0;
    end
    h_oe = 1'b0;
    #100 if (mdio_oe) drove = 1'b1;
  endtask : xfer
endmodule : mgmt_host_model

// ===== tb.sv
// Self-checking bench of the management serial unit
`timescale 1ns/10ps
module tb;
  logic        mclk, rst, mdc_link, mdio_in, mdio_out, mdio_oe, fp, rdy, req, cmt;
  logic        hold, wr, eep_wr, pclk, pin, pout, poe, phy_bit;
  logic [7:0]  raddr, waddr, eep_addr, cnt, ncmt, wn, k;
  logic [31:0] rdata, wdata, eep_data;
  int          n_errors, n_compared;
  // Fabric answer carries address and capture number in each half
  assign rdata = {raddr, cnt, raddr, cnt};
  assign pin = poe ? pout : phy_bit;
  always @(posedge mclk) begin
    if (req) cnt <= cnt + 8'h01;
    if (cmt) ncmt <= ncmt + 8'h01;
    if (wr) wn <= wn + 8'h01;
  end
  mgmt_host_model host (.mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc_link(mdc_link),
    .mdio_in(mdio_in));
  mgmt_serial_top uut (.mclk(mclk), .rst(rst), .mdc_link(mdc_link), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .full_power_state(fp), .device_ready(rdy),
    .csr_rd_req(req), .csr_rd_addr(raddr), .csr_rd_data(rdata),
    .csr_rd_hit(raddr != 8'h3f), .csr_rd_single(raddr == 8'h11), .csr_rd_commit(cmt),
    .csr_rd_hold(hold), .csr_wr(wr), .csr_wr_addr(waddr), .csr_wr_data(wdata),
    .eep_wr(eep_wr), .eep_addr(eep_addr), .eep_data(eep_data), .port0_mgmt_clock(pclk),
    .port0_mgmt_data_in(pin), .port0_mgmt_data_out(pout), .port0_mgmt_data_oe(poe));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // ********************
  // Shared tasks
  // ********************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic h, input logic [15:0] e);
    logic [16:0] v;
    logic d;
    host.xfer(2'h2, a, h, 16'h0, v, d);
    chk({14'h0, d, v}, {16'h0, e});
  endtask : rd
  task automatic grab(input logic [63:0] r, output logic [63:0] f);
    for (int i = 0; i < 4000 && !poe; i++) @(posedge mclk);
    chk({31'h0, poe}, 32'h1);
    for (int i = 0; i < 64; i++) begin
      @(posedge pclk);
      f = {f[62:0], pin};
      @(negedge mclk);
      phy_bit = (i < 63) ? r[62 - i] : 1'b1;
    end
    // A start is refused while busy; a write frame lets go of the line as busy ends
    for (int i = 0; i < 400 && poe; i++) @(posedge mclk);
  endtask : grab
  task automatic eep(input logic [7:0] a, input logic [31:0] d);
    @(negedge mclk);
    eep_addr = a;
    eep_data = d;
    eep_wr = 1'b1;
    @(negedge mclk);
    eep_wr = 1'b0;
  endtask : eep
  task automatic end_sim;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  // ********************
  // Scenarios
  // ********************
  task automatic t_reads;
    rd(8'h12, 1'b1, {8'h12, k});
    rd(8'h12, 1'b0, {8'h12, k});
    chk({24'h0, ncmt}, 32'h1);
    rd(8'h13, 1'b1, {8'h13, k + 8'h1});
    rd(8'h13, 1'b1, {8'h13, k + 8'h2});
    rd(8'h13, 1'b0, {8'h13, k + 8'h2});
    rd(8'h3f, 1'b0, 16'h0);
    rd(8'h3f, 1'b1, 16'h0);
    rd(8'h11, 1'b1, {8'h11, k + 8'h4});
    rd(8'h14, 1'b0, {8'h14, k + 8'h5});
    rd(8'h14, 1'b1, {8'h14, k + 8'h5});
    k = k + 8'h6;
    $display("t_reads done");
  endtask : t_reads
  task automatic t_power;
    logic [16:0] v;
    logic d;
    @(negedge mclk) rdy = 1'b0;
    rd(8'h15, 1'b1, {8'h15, k});
    rd(8'h16, 1'b0, {8'h16, k + 8'h1});
    @(negedge mclk) rdy = 1'b1;
    fp = 1'b0;
    host.xfer(2'h2, 8'h12, 1'b1, 16'h0, v, d);
    chk({14'h0, d, v}, {15'h0, 17'h1ffff});
    @(negedge mclk) fp = 1'b1;
    rd(8'h12, 1'b1, {8'h12, k + 8'h2});
    rd(8'h12, 1'b0, {8'h12, k + 8'h2});
    $display("t_power done");
  endtask : t_power
  task automatic t_write;
    logic [16:0] v;
    logic d;
    host.xfer(2'h1, 8'h21, 1'b0, 16'hbeef, v, d);
    chk({31'h0, d}, 32'h0);
    host.xfer(2'h1, 8'h21, 1'b1, 16'h1234, v, d);
    chk({31'h0, d}, 32'h0);
    for (int i = 0; i < 50 && wn == 8'h0; i++) @(posedge mclk);
    chk({24'h0, waddr}, 32'h21);
    chk(wdata, 32'h1234beef);
    $display("t_write done");
  endtask : t_write
  task automatic t_master;
    logic [63:0] f;
    eep(8'h29, 32'h1234);
    eep(8'h2a, {16'h0, 5'h03, 5'h05, 4'h0, 2'b10});
    grab({64{1'b1}}, f);
    chk(f[63:32], 32'hffffffff);
    chk(f[31:0], {4'b0101, 5'h03, 5'h05, 2'b10, 16'h1234});
    eep(8'h2a, {16'h0, 5'h03, 5'h05, 6'h0});
    grab({{47{1'b1}}, 1'b0, 16'hc3a5}, f);
    chk(f[31:0], {4'b0110, 5'h03, 5'h05, 2'b10, 16'hc3a5});
    repeat (40) @(negedge mclk);
    chk({31'h0, poe}, 32'h0);
    rd(8'h29, 1'b0, 16'hc3a5);
    $display("t_master done");
  endtask : t_master
  initial begin
    rst = 1'b1;
    fp = 1'b1;
    rdy = 1'b1;
    eep_wr = 1'b0;
    eep_addr = 8'h0;
    eep_data = 32'h0;
    phy_bit = 1'b1;
    cnt = 8'h0;
    ncmt = 8'h0;
    wn = 8'h0;
    k = 8'h0;
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    t_reads;
    t_power;
    t_write;
    t_master;
    end_sim;
  end
  initial begin
    #1000000;
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim;
  end
endmodule : tb
